// ===== prev_space_pkg.sv
// Shared constants and carriers for the previous-space move core.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package prev_space_pkg;

  // Opcode field in bits 14..6; bit 15 is ignored, no split data and instruction spaces
  localparam logic [8:0]  OP_MFP       = 9'h035;
  localparam logic [8:0]  OP_MTP       = 9'h036;
  localparam logic [15:0] OP_HALT      = 16'h0000;
  localparam logic [15:0] OP_RESET     = 16'h0005;
  localparam logic [15:0] HALT_VECTOR  = 16'h0008;

  // Processor status word fields
  localparam int          PSW_CUR_LO   = 14;
  localparam int          PSW_PREV_LO  = 12;
  localparam int          PSW_N        = 3;
  localparam int          PSW_Z        = 2;
  localparam int          PSW_V        = 1;
  localparam logic [1:0]  MODE_KERNEL  = 2'h0;
  localparam logic [1:0]  MODE_USER    = 2'h3;

  // Register numbers and step sizes
  localparam logic [2:0]  REG_SP       = 3'h6;
  localparam logic [2:0]  REG_PC       = 3'h7;
  localparam logic [15:0] WORD_STEP    = 16'h0002;

  // Memory management status register zero
  localparam int          SR0_ENABLE   = 0;
  localparam logic [15:0] SR0_WMASK    = 16'h0001;

  // Reset values and the kernel stack limit
  localparam logic [15:0] PSW_RST      = 16'h0000;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [15:0] SR0_RST      = 16'h0000;
  localparam logic [15:0] STACK_LIMIT  = 16'h0100;

  // Bus register indices (byte offset = 4 * index)
  localparam int          NUM_REGS     = 11;
  localparam logic [3:0]  IDX_SR0      = 4'h0;
  localparam logic [3:0]  IDX_PSW      = 4'h1;
  localparam logic [3:0]  IDX_PC       = 4'h2;
  localparam logic [3:0]  IDX_KSP      = 4'h3;
  localparam logic [3:0]  IDX_USP      = 4'h4;
  localparam logic [3:0]  IDX_GPR0     = 4'h5;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        reloc;
    logic [1:0]  map;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [15:0] data;
  } reg_wr_t;

endpackage

// ===== ahb_reg_port.sv
// AHB-Lite slave giving software access to the core's registers.
// Assumes one slave on the bus; answers with zero wait states.
`timescale 1ns/10ps
module ahb_reg_port (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [10:0][15:0]     view,
  output prev_space_pkg::reg_wr_t    reg_wr
);

  typedef struct packed {
    logic        wr;
    logic [3:0]  idx;
    logic [31:0] rdata;
  } port_t;

  port_t s;
  port_t next_s;
  logic  mapped;

  assign mapped = (haddr[31:6] == 26'h0) &&
                  (haddr[5:2] < 4'(prev_space_pkg::NUM_REGS));

  always_comb begin
    next_s    = s;
    next_s.wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_s.idx = haddr[5:2];
      if (hwrite) begin
        // Narrow or unmapped writes are dropped
        next_s.wr = mapped && (hsize == prev_space_pkg::HSIZE_WORD);
      end else begin
        // Read data is captured here so it stands all data phase
        next_s.rdata = mapped ? {16'h0000, view[haddr[5:2]]} : 32'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata      = s.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign reg_wr.en   = s.wr;
  assign reg_wr.idx  = s.idx;
  assign reg_wr.data = hwdata[15:0];

endmodule // ahb_reg_port

// ===== prev_space_core.sv
// Execution core for previous-space moves, mode limits and trap entry.
// Assumes a relocation unit that answers each held request with mem_ack.
`timescale 1ns/10ps
module prev_space_core #(
  parameter logic [15:0] STACK_LIMIT = prev_space_pkg::STACK_LIMIT
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   instr_valid,
  input  wire logic [15:0]            instr,
  output logic                        instr_ready,
  input  wire logic                   trap_req,
  input  wire logic [15:0]            trap_vector,
  output logic                        trap_ack,
  output prev_space_pkg::mem_req_t    mem,
  input  wire logic                   mem_ack,
  input  wire logic [15:0]            mem_rdata,
  output logic                        halted,
  output logic                        bus_reset,
  output logic                        stack_fault,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp
);

  typedef enum {
    ST_IDLE, ST_POP, ST_ADDR, ST_INDEX, ST_PTR, ST_READ, ST_WRITE,
    ST_PUSH, ST_VEC_PC, ST_VEC_PS, ST_PUSH_PS, ST_PUSH_PC, ST_HALT
  } step_t;

  typedef struct packed {
    step_t                    state;
    logic [5:0][15:0]         gpr;
    logic [15:0]              kernel_stack_pointer;
    logic [15:0]              usp;
    logic [15:0]              pc;
    logic [15:0]              psw;
    logic [15:0]              sr0;
    logic                     is_mtp;
    logic [5:0]               spec;
    logic [15:0]              temp;
    logic [15:0]              ea;
    logic [15:0]              old_ps;
    logic [15:0]              vec;
    prev_space_pkg::mem_req_t mem;
    logic                     halted;
    logic                     bus_reset;
    logic                     stack_fault;
    logic                     trap_ack;
  } core_t;

  core_t                   s;
  core_t                   next_s;
  prev_space_pkg::reg_wr_t reg_wr;
  logic [10:0][15:0]       view;

  // Stack pointer 6 depends on the mode asked for
  function automatic logic [15:0] get_reg(core_t c, logic [2:0] rn,
                                          logic [1:0] md);
    case (rn)
      prev_space_pkg::REG_SP: begin
        get_reg = (md == prev_space_pkg::MODE_USER) ? c.usp : c.kernel_stack_pointer;
      end
      prev_space_pkg::REG_PC: begin
        get_reg = c.pc;
      end
      default: begin
        get_reg = c.gpr[rn];
      end
    endcase
  endfunction

  function automatic core_t set_reg(core_t c, logic [2:0] rn,
                                    logic [1:0] md, logic [15:0] v);
    core_t r;
    r = c;
    case (rn)
      prev_space_pkg::REG_SP: begin
        if (md == prev_space_pkg::MODE_USER) begin
          r.usp = v;
        end else begin
          r.kernel_stack_pointer = v;
        end
      end
      prev_space_pkg::REG_PC: begin
        r.pc = v;
      end
      default: begin
        r.gpr[rn] = v;
      end
    endcase
    return r;
  endfunction

  // N and Z from the word, V cleared, C left alone
  function automatic logic [15:0] set_nz(logic [15:0] p, logic [15:0] v);
    logic [15:0] r;
    r = p;
    r[prev_space_pkg::PSW_N] = v[15];
    r[prev_space_pkg::PSW_Z] = (v == 16'h0000);
    r[prev_space_pkg::PSW_V] = 1'b0;
    return r;
  endfunction

  // A request is held until the relocation unit acknowledges it
  function automatic prev_space_pkg::mem_req_t issue(logic we,
      logic [1:0] map, logic [15:0] addr, logic [15:0] wd, logic reloc);
    prev_space_pkg::mem_req_t m;
    m.req   = 1'b1;
    m.we    = we;
    m.reloc = reloc;
    m.map   = map;
    m.addr  = addr;
    m.wdata = wd;
    return m;
  endfunction

  always_comb begin
    logic [1:0]  cur;
    logic [1:0]  prv;
    logic [2:0]  rn;
    logic [2:0]  md;
    logic [15:0] rv;
    logic [15:0] sp_new;
    logic        done;
    logic        reloc;
    step_t       fin;
    cur    = s.psw[prev_space_pkg::PSW_CUR_LO +: 2];
    prv    = s.psw[prev_space_pkg::PSW_PREV_LO +: 2];
    rn     = s.spec[2:0];
    md     = s.spec[5:3];
    rv     = get_reg(s, rn, cur);
    sp_new = get_reg(s, prev_space_pkg::REG_SP, cur) -
             prev_space_pkg::WORD_STEP;
    done   = s.mem.req && mem_ack;
    reloc  = s.sr0[prev_space_pkg::SR0_ENABLE];
    fin    = s.is_mtp ? ST_WRITE : ST_READ;
    next_s             = s;
    next_s.bus_reset   = 1'b0;
    next_s.stack_fault = 1'b0;
    next_s.trap_ack    = 1'b0;
    if (done) begin
      next_s.mem.req = 1'b0;
    end
    case (s.state)
      ST_IDLE: begin
        if (trap_req) begin
          next_s.vec      = trap_vector;
          next_s.trap_ack = 1'b1;
          next_s.state    = ST_VEC_PC;
        end else if (instr_valid) begin
          next_s.spec = instr[5:0];
          // Bit 15 is ignored: no split instruction and data spaces
          if (instr[14:6] == prev_space_pkg::OP_MFP) begin
            next_s.is_mtp = 1'b0;
            next_s.state  = ST_ADDR;
          end else if (instr[14:6] == prev_space_pkg::OP_MTP) begin
            next_s.is_mtp = 1'b1;
            next_s.state  = ST_POP;
          end else if (instr == prev_space_pkg::OP_HALT) begin
            if (cur == prev_space_pkg::MODE_USER) begin
              next_s.vec   = prev_space_pkg::HALT_VECTOR;
              next_s.state = ST_VEC_PC;
            end else begin
              next_s.halted = 1'b1;
              next_s.state  = ST_HALT;
            end
          end else if (instr == prev_space_pkg::OP_RESET) begin
            next_s.bus_reset = (cur != prev_space_pkg::MODE_USER);
          end
        end
      end
      ST_POP: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, cur, get_reg(s, prev_space_pkg::REG_SP,
                             cur), 16'h0000, reloc);
        end else if (done) begin
          next_s.temp  = mem_rdata;
          next_s.psw   = set_nz(s.psw, mem_rdata);
          next_s       = set_reg(next_s, prev_space_pkg::REG_SP, cur,
                                 s.mem.addr + prev_space_pkg::WORD_STEP);
          next_s.state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        case (md)
          3'h0: begin
            // Register 6 names the previous mode's stack pointer
            if (s.is_mtp) begin
              next_s       = set_reg(s, rn, prv, s.temp);
              next_s.state = ST_IDLE;
            end else begin
              next_s.temp  = get_reg(s, rn, prv);
              next_s.psw   = set_nz(s.psw, get_reg(s, rn, prv));
              next_s.state = ST_PUSH;
            end
          end
          3'h1: begin
            next_s.ea    = rv;
            next_s.state = fin;
          end
          3'h2: begin
            next_s       = set_reg(s, rn, cur,
                                   rv + prev_space_pkg::WORD_STEP);
            next_s.ea    = rv;
            next_s.state = fin;
          end
          3'h3: begin
            next_s       = set_reg(s, rn, cur,
                                   rv + prev_space_pkg::WORD_STEP);
            next_s.ea    = rv;
            next_s.state = ST_PTR;
          end
          3'h4: begin
            next_s       = set_reg(s, rn, cur,
                                   rv - prev_space_pkg::WORD_STEP);
            next_s.ea    = rv - prev_space_pkg::WORD_STEP;
            next_s.state = fin;
          end
          3'h5: begin
            next_s       = set_reg(s, rn, cur,
                                   rv - prev_space_pkg::WORD_STEP);
            next_s.ea    = rv - prev_space_pkg::WORD_STEP;
            next_s.state = ST_PTR;
          end
          default: begin
            next_s.state = ST_INDEX;
          end
        endcase
      end
      ST_INDEX: begin
        // Index word follows the instruction, fetched in current space
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, cur, s.pc, 16'h0000, reloc);
        end else if (done) begin
          next_s.pc    = s.pc + prev_space_pkg::WORD_STEP;
          next_s.ea    = get_reg(next_s, rn, cur) + mem_rdata;
          next_s.state = (md == 3'h6) ? fin : ST_PTR;
        end
      end
      ST_PTR: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, cur, s.ea, 16'h0000, reloc);
        end else if (done) begin
          next_s.ea    = mem_rdata;
          next_s.state = fin;
        end
      end
      ST_READ: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, prv, s.ea, 16'h0000, reloc);
        end else if (done) begin
          next_s.temp  = mem_rdata;
          next_s.psw   = set_nz(s.psw, mem_rdata);
          next_s.state = ST_PUSH;
        end
      end
      ST_WRITE: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b1, prv, s.ea, s.temp, reloc);
        end else if (done) begin
          next_s.state = ST_IDLE;
        end
      end
      ST_PUSH: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b1, cur, sp_new, s.temp, reloc);
          // Only a flag: the push itself still goes ahead
          next_s.stack_fault = (cur != prev_space_pkg::MODE_USER) &&
                               (sp_new < STACK_LIMIT);
        end else if (done) begin
          next_s       = set_reg(next_s, prev_space_pkg::REG_SP, cur,
                                 s.mem.addr);
          next_s.state = ST_IDLE;
        end
      end
      ST_VEC_PC: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, prev_space_pkg::MODE_KERNEL, s.vec,
                             16'h0000, reloc);
        end else if (done) begin
          next_s.ea    = mem_rdata;
          next_s.state = ST_VEC_PS;
        end
      end
      ST_VEC_PS: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b0, prev_space_pkg::MODE_KERNEL,
                             s.vec + prev_space_pkg::WORD_STEP,
                             16'h0000, reloc);
        end else if (done) begin
          next_s.old_ps = s.psw;
          // New mode switches stack and page set from here on
          next_s.psw    = {mem_rdata[15:14], cur,
                           mem_rdata[11:0]};
          next_s.state  = ST_PUSH_PS;
        end
      end
      ST_PUSH_PS: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b1, cur, sp_new, s.old_ps, reloc);
        end else if (done) begin
          next_s       = set_reg(next_s, prev_space_pkg::REG_SP, cur,
                                 s.mem.addr);
          next_s.state = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (!s.mem.req) begin
          next_s.mem = issue(1'b1, cur, sp_new, s.pc, reloc);
        end else if (done) begin
          next_s       = set_reg(next_s, prev_space_pkg::REG_SP, cur,
                                 s.mem.addr);
          next_s.pc    = s.ea;
          next_s.state = ST_IDLE;
        end
      end
      ST_HALT: begin
        next_s.halted = 1'b1;
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    // Software writes land last and win over the sequencer
    if (reg_wr.en) begin
      case (reg_wr.idx)
        prev_space_pkg::IDX_SR0: begin
          next_s.sr0 = reg_wr.data & prev_space_pkg::SR0_WMASK;
        end
        prev_space_pkg::IDX_PSW: next_s.psw = reg_wr.data;
        prev_space_pkg::IDX_PC:  next_s.pc  = reg_wr.data;
        prev_space_pkg::IDX_KSP: next_s.kernel_stack_pointer = reg_wr.data;
        prev_space_pkg::IDX_USP: next_s.usp = reg_wr.data;
        default: begin
          next_s.gpr[3'(reg_wr.idx - prev_space_pkg::IDX_GPR0)] =
            reg_wr.data;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.psw   <= prev_space_pkg::PSW_RST;
      s.pc    <= prev_space_pkg::PC_RST;
      s.sr0   <= prev_space_pkg::SR0_RST;
    end else begin
      s <= next_s;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_view
      assign view[g + 5] = s.gpr[g];
    end
  endgenerate
  assign view[0] = s.sr0;
  assign view[1] = s.psw;
  assign view[2] = s.pc;
  assign view[3] = s.kernel_stack_pointer;
  assign view[4] = s.usp;

  ahb_reg_port u_port (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .view      (view),
    .reg_wr    (reg_wr)
  );

  assign instr_ready = (s.state == ST_IDLE) && !trap_req;
  assign trap_ack    = s.trap_ack;
  assign mem         = s.mem;
  assign halted      = s.halted;
  assign bus_reset   = s.bus_reset;
  assign stack_fault = s.stack_fault;

endmodule // prev_space_core

// ===== prev_space_core_properties.sv
// Port checks for the previous-space core.
// Assumes binding to prev_space_core; one clock, sync reset.
`timescale 1ns/10ps
module prev_space_properties #(
  parameter logic [15:0] STACK_LIMIT = prev_space_pkg::STACK_LIMIT
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     instr_ready,
  input wire logic                     trap_req,
  input wire logic                     trap_ack,
  input wire prev_space_pkg::mem_req_t mem,
  input wire logic                     mem_ack,
  input wire logic                     halted,
  input wire logic                     bus_reset,
  input wire logic                     stack_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_req_held:
    assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
    else $error("memory request changed before ack");
  chk_req_drop:
    assert property (mem.req && mem_ack |=> !mem.req)
    else $error("memory request kept after ack");
  chk_ack_pulse:
    assert property (trap_ack |=> !trap_ack)
    else $error("trap ack longer than one cycle");
  chk_ack_cause:
    assert property (trap_ack |-> $past(trap_req))
    else $error("trap ack without request");
  chk_vector_read:
    assert property (trap_ack |-> ##[0:3] (mem.req && !mem.we
      && mem.map == prev_space_pkg::MODE_KERNEL))
    else $error("vector not read through kernel map");
  chk_trap_first:
    assert property (trap_ack |-> !instr_ready)
    else $error("instruction accepted during trap entry");
  chk_halt_holds:
    assert property (halted |=> halted)
    else $error("halt released without reset");
  chk_reset_pulse:
    assert property (bus_reset |=> !bus_reset)
    else $error("bus reset longer than one cycle");
  chk_fault_pulse:
    assert property (stack_fault |=> !stack_fault)
    else $error("stack fault longer than one cycle");

  cover property (trap_ack);
  cover property ($rose(halted));
  cover property (bus_reset);
endmodule // prev_space_properties

bind prev_space_core prev_space_properties #(
  .STACK_LIMIT(STACK_LIMIT)
) u_chk (
  .clk(clk), .rst(rst), .instr_ready(instr_ready), .trap_req(trap_req),
  .trap_ack(trap_ack), .mem(mem), .mem_ack(mem_ack), .halted(halted),
  .bus_reset(bus_reset), .stack_fault(stack_fault)
);

// ===== mem_partner.sv
// Relocation unit and memory model behind the core's memory port.
// Assumes the bench preloads ram; ack latency set by lat.
`timescale 1ns/10ps
module mem_partner (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire prev_space_pkg::mem_req_t mem,
  input  wire logic [3:0]               lat,
  output logic                          mem_ack,
  output logic [15:0]                   mem_rdata
);
  logic [15:0] ram [0:511];
  logic [8:0]  ix;
  int          cnt;
  // Spaces merge when relocation is off
  assign ix = {mem.map[0] & mem.reloc, mem.addr[8:1]};
  initial mem_rdata = 16'h5a5a;
  always @(posedge clk) begin
    if (rst || !mem.req || mem_ack) begin
      cnt       <= 0;
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata; // Stale data never looks valid
    end else if (cnt < lat) begin
      cnt <= cnt + 1;
    end else begin
      mem_ack <= 1'b1;
      if (mem.we) ram[ix] <= mem.wdata;
      else mem_rdata <= ram[ix];
    end
  end
endmodule // mem_partner

// ===== previous_space_move_and_mode_control_tb.sv
// Bench for the previous-space core with a memory model behind it.
// Assumes 10 MHz clock; registers reached over AHB-Lite.
`timescale 1ns/10ps
module previous_space_move_and_mode_control_tb;
  logic                     clk, rst, instr_valid, instr_ready, trap_req;
  logic                     trap_ack, mem_ack, halted, bus_reset;
  logic                     stack_fault, hsel, hwrite, hreadyout, hresp;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [3:0]               lat;
  logic [15:0]              instr, trap_vector, mem_rdata, q;
  logic [31:0]              haddr, hwdata, hrdata;
  prev_space_pkg::mem_req_t mem;
  int                       n_mismatch, checks, n_rst, n_flt;

  prev_space_core u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .trap_req(trap_req),
    .trap_vector(trap_vector), .trap_ack(trap_ack), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .halted(halted),
    .bus_reset(bus_reset), .stack_fault(stack_fault), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  mem_partner u_mem (.clk(clk), .rst(rst), .mem(mem), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bus_reset === 1'b1) n_rst++;
    if (stack_fault === 1'b1) n_flt++;
  end

  task automatic check(input string nm, input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      check("wait", 16'h0, 16'h1);
      complete_run;
    end
  endtask
  task automatic hwait;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end
    while (hreadyout !== 1'b1 && n < 300);
    tmo(n);
  endtask
  // Whole-word single transfers only
  task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    hwait;
    q = hrdata[15:0];
    check("hresp", {15'h0, hresp}, 16'h0);
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [15:0] e);
    ahb(1'b0, a, 16'h0);
    check(nm, q, e);
  endtask
  // Idle means ready with no memory cycle for three edges
  task automatic idle;
    int n, c;
    n = 0;
    c = 0;
    while (c < 3 && n < 300) begin
      @(posedge clk);
      n++;
      c = (instr_ready === 1'b1 && mem.req === 1'b0) ? c + 1 : 0;
    end
    tmo(n);
  endtask
  task automatic run(input logic [15:0] op);
    instr_valid <= 1'b1;
    instr <= op;
    @(posedge clk);
    instr_valid <= 1'b0;
    idle;
  endtask
  function automatic logic [15:0] fl(input logic [15:0] v);
    return {12'h0, v[15], v == 16'h0, 2'h0};
  endfunction

  task automatic sp_moves;
    logic [15:0] v;
    for (int b = 0; b < 2; b++) begin
      v = b ? 16'h8002 : 16'h0000;
      ahb(1'b1, 8'h10, v);
      ahb(1'b1, 8'h0c, 16'h0040);
      n_flt = 0;
      run({b[0], prev_space_pkg::OP_MFP, 6'o06});
      check("pushed", u_mem.ram[9'h01f], v);
      check("fault", n_flt[15:0], 16'h1);
      rd(8'h0c, "ksp", 16'h003e);
      rd(8'h04, "flags", 16'h3000 | fl(v));
      u_mem.ram[9'h01f] = ~v;
      run({b[0], prev_space_pkg::OP_MTP, 6'o06});
      rd(8'h10, "usp", ~v);
      rd(8'h0c, "ksp pop", 16'h0040);
      rd(8'h04, "flags to", 16'h3000 | fl(~v));
    end
  endtask
  task automatic ind_moves;
    lat <= 4'h3;
    ahb(1'b1, 8'h1c, 16'h0010);
    ahb(1'b1, 8'h0c, 16'h0040);
    u_mem.ram[9'h008] = 16'h0020;
    u_mem.ram[9'h110] = 16'h8001;
    u_mem.ram[9'h010] = 16'h1234;
    run({1'b0, prev_space_pkg::OP_MFP, 6'o32});
    check("prev word", u_mem.ram[9'h01f], 16'h8001);
    rd(8'h1c, "r2", 16'h0012);
    lat <= 4'h0;
    u_mem.ram[9'h01f] = 16'h0400;
    run({1'b0, prev_space_pkg::OP_MTP, 6'o07});
    rd(8'h08, "pc", 16'h0400);
  endtask
  task automatic modes;
    int n;
    ahb(1'b1, 8'h04, 16'hf000);
    ahb(1'b1, 8'h0c, 16'h0040);
    ahb(1'b1, 8'h10, 16'h0040);
    u_mem.ram[9'h004] = 16'h0200;
    u_mem.ram[9'h005] = 16'h0005;
    n_rst = 0;
    run(prev_space_pkg::OP_RESET);
    check("user reset", n_rst[15:0], 16'h0);
    n_flt = 0;
    run({1'b0, prev_space_pkg::OP_MFP, 6'o00});
    check("user fault", n_flt[15:0], 16'h0);
    check("user push", u_mem.ram[9'h11f], 16'h0000);
    run(prev_space_pkg::OP_HALT);
    check("halted", {15'h0, halted}, 16'h0);
    rd(8'h04, "trap psw", 16'h3005);
    rd(8'h08, "trap pc", 16'h0200);
    rd(8'h0c, "trap ksp", 16'h003c);
    check("old psw", u_mem.ram[9'h01f], 16'hf004);
    trap_vector <= 16'h0020;
    u_mem.ram[9'h010] = 16'h0300;
    u_mem.ram[9'h011] = 16'h0005;
    trap_req <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end
    while (trap_ack !== 1'b1 && n < 300);
    tmo(n);
    trap_req <= 1'b0;
    idle;
    rd(8'h04, "irq psw", 16'h0005);
    rd(8'h08, "irq pc", 16'h0300);
    check("irq old psw", u_mem.ram[9'h01d], 16'h3005);
    run(prev_space_pkg::OP_RESET);
    check("kernel reset", n_rst[15:0], 16'h1);
    instr_valid <= 1'b1;
    instr <= prev_space_pkg::OP_HALT;
    @(posedge clk);
    instr_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end
    while (halted !== 1'b1 && n < 300);
    tmo(n);
    check("kernel halt", {15'h0, halted}, 16'h1);
  endtask

  initial begin
    rst = 1'b1;
    {instr_valid, trap_req, hsel, hwrite} = 4'h0;
    instr = 16'h0;
    trap_vector = prev_space_pkg::HALT_VECTOR;
    {haddr, hwdata, htrans, lat} = 70'h0;
    hsize = prev_space_pkg::HSIZE_WORD;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ready", {15'h0, instr_ready}, 16'h1);
    rd(8'h00, "sr0", 16'h0);
    rd(8'h04, "psw", prev_space_pkg::PSW_RST);
    ahb(1'b1, 8'h04, 16'h3000);
    ahb(1'b1, 8'h00, 16'h0001);
    rd(8'h00, "sr0 on", 16'h0001);
    sp_moves;
    ind_moves;
    modes;
    complete_run;
  end
endmodule // previous_space_move_and_mode_control_tb
